// >>> logic/rtcs_regs.vh
// register map, bus constants and divider timing for the calendar clock serial slave
`ifndef RTCS_REGS_VH
`define RTCS_REGS_VH

`define RTCS_SLAVE_ADDR 7'h68
`define RTCS_ADDR_SEC 4'h0
`define RTCS_ADDR_CTRL 4'h7
`define RTCS_ADDR_CHARGE 4'h8
`define RTCS_ADDR_FLAG 4'h9
`define RTCS_ADDR_LAST_CLOCK 4'h7
`define RTCS_ADDR_LAST 4'h9
`define RTCS_PTR_RESET 4'h0
`define RTCS_LAST_BIT 4'h7
`define RTCS_ACK_BIT 4'h8

`define RTCS_SEC_OSC_DIS_BIT 7
`define RTCS_FLAG_OSF_BIT 7
`define RTCS_CTRL_OUT_BIT 7
`define RTCS_CTRL_FT_BIT 6
`define RTCS_CTRL_SIGN_BIT 5
`define RTCS_CTRL_RESET 8'h80
`define RTCS_CHARGE_RESET 8'h00
`define RTCS_CHARGE_KEY 4'hA
`define RTCS_FLAG_RESET 8'h80

`define RTCS_DIODE_NONE 2'h1
`define RTCS_DIODE_ONE 2'h2
`define RTCS_RES_OFF 2'h0

`define RTCS_TRIM_CYCLE_MIN 6'h3F
`define RTCS_TRIM_MAX_MIN 6'h3D
`define RTCS_SEC_PER_MIN 6'h3B
`define RTCS_DIV_LOW_WRAP 8'hFF
`define RTCS_DIV_HIGH_WRAP 7'h7F
`define RTCS_BLANK_CYCLES 9'h080
`define RTCS_INSERT_CYCLES 9'h100
`define RTCS_FT_TAP 5

`endif

// >>> logic/rtcs_trim_divider.v
// oscillator divider chain with rate trim at the divide-by-256 stage
`timescale 1ns/1ps
`include "rtcs_regs.vh"
module rtcs_trim_divider (
  input wire ref_clk,
  input wire rst_b,
  input wire osc_tick,
  input wire div_clear,
  input wire [4:0] trim_magnitude,
  input wire trim_sign,
  output reg ft_square_ff,
  output reg sec_pulse_ff
);

////////////////////////////////////////////////////////////////////////
reg [7:0] low_ff;
reg [6:0] high_ff;
reg [5:0] sec_ff;
reg [5:0] min_ff;
reg [8:0] adj_ff;
reg adj_used_ff;
reg [7:0] nxt_low;
reg [6:0] high_add;
reg [8:0] low_sum;
wire adj_window;
wire adj_active;
wire insert_tick;
wire blank_tick;
wire stage_wrap;

// adjust allowed only in first 2N minutes, of at most 62
assign adj_window = (min_ff < {trim_magnitude, 1'b0}) && (min_ff <= `RTCS_TRIM_MAX_MIN) && !adj_used_ff;
assign adj_active = osc_tick && (adj_ff != 9'h000);
assign insert_tick = adj_active && trim_sign;
assign blank_tick = adj_active && !trim_sign;

// inserted ticks count twice at the 256 stage, blanked ones not at all
always @* begin
  low_sum = {1'b0, low_ff} + {7'h00, insert_tick, osc_tick && !blank_tick && !insert_tick};
  nxt_low = low_sum[7:0];
  high_add = {6'h00, low_sum[8]};
end
assign stage_wrap = low_sum[8] && (high_ff == `RTCS_DIV_HIGH_WRAP);

////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk) begin
  if (!rst_b || div_clear) begin
    low_ff <= 8'h00;
    high_ff <= 7'h00;
    sec_ff <= 6'h00;
    min_ff <= 6'h00;
    adj_ff <= 9'h000;
    adj_used_ff <= 1'b0;
    sec_pulse_ff <= 1'b0;
  end else begin
    sec_pulse_ff <= 1'b0;
    low_ff <= nxt_low;
    high_ff <= high_ff + high_add;
    if (adj_active) begin
      adj_ff <= adj_ff - 9'h001;
    end
    if (stage_wrap) begin
      sec_pulse_ff <= 1'b1;
      if (adj_window && trim_magnitude != 5'h00) begin
        adj_ff <= trim_sign ? `RTCS_INSERT_CYCLES : `RTCS_BLANK_CYCLES;
        adj_used_ff <= 1'b1;
      end
      if (sec_ff == `RTCS_SEC_PER_MIN) begin
        sec_ff <= 6'h00;
        adj_used_ff <= 1'b0;
        min_ff <= (min_ff == `RTCS_TRIM_CYCLE_MIN) ? 6'h00 : min_ff + 6'h01;
      end else begin
        sec_ff <= sec_ff + 6'h01;
      end
    end
  end
end

// test square wave from an untrimmed free count
reg [`RTCS_FT_TAP:0] ft_cnt_ff;
always @(posedge ref_clk) begin
  if (!rst_b || div_clear) begin
    ft_cnt_ff <= {(`RTCS_FT_TAP + 1){1'b0}};
    ft_square_ff <= 1'b0;
  end else begin
    if (osc_tick) begin
      ft_cnt_ff <= ft_cnt_ff + 1'b1;
    end
    ft_square_ff <= ft_cnt_ff[`RTCS_FT_TAP];
  end
end

endmodule

// >>> logic/rtcs_serial_slave.v
// two-wire slave with control, charge-select and oscillator halt flag registers
`timescale 1ns/1ps
`include "rtcs_regs.vh"
module rtcs_serial_slave (
  input wire ref_clk,
  input wire rst_b,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire osc_clk_in,
  input wire osc_running_in,
  output reg test_output_pin,
  output reg charge_enable,
  output reg diode_select_field,
  output reg [1:0] resistor_select_field,
  output reg osc_disable_bit,
  output reg sec_pulse,
  output reg [7:0] time_wr_data,
  output reg [3:0] time_wr_addr,
  output reg time_wr_strobe,
  input wire [7:0] time_rd_data,
  output wire [3:0] time_rd_addr
);

////////////////////////////////////////////////////////////////////////
// two-stage synchronisers for pins and oscillator
reg [1:0] scl_sync_ff;
reg [1:0] sda_sync_ff;
reg [1:0] osc_sync_ff;
reg [1:0] run_sync_ff;
reg scl_d_ff;
reg sda_d_ff;
reg osc_d_ff;
reg run_d_ff;

always @(posedge ref_clk) begin
  if (!rst_b) begin
    scl_sync_ff <= 2'h3;
    sda_sync_ff <= 2'h3;
    osc_sync_ff <= 2'h0;
    run_sync_ff <= 2'h0;
    scl_d_ff <= 1'b1;
    sda_d_ff <= 1'b1;
    osc_d_ff <= 1'b0;
    run_d_ff <= 1'b0;
  end else begin
    scl_sync_ff <= {scl_sync_ff[0], scl_in};
    sda_sync_ff <= {sda_sync_ff[0], sda_in};
    osc_sync_ff <= {osc_sync_ff[0], osc_clk_in};
    run_sync_ff <= {run_sync_ff[0], osc_running_in};
    scl_d_ff <= scl_sync_ff[1];
    sda_d_ff <= sda_sync_ff[1];
    osc_d_ff <= osc_sync_ff[1];
    run_d_ff <= run_sync_ff[1];
  end
end

wire scl_s = scl_sync_ff[1];
wire sda_s = sda_sync_ff[1];
// 100 MHz sampling leaves wide margin at 100kHz and 400kHz
wire scl_rise = scl_s && !scl_d_ff;
wire scl_fall = !scl_s && scl_d_ff;
wire start_cond = scl_s && scl_d_ff && !sda_s && sda_d_ff;
wire stop_cond = scl_s && scl_d_ff && sda_s && !sda_d_ff;
wire osc_tick = osc_sync_ff[1] && !osc_d_ff;
wire osc_stop_edge = !run_sync_ff[1] && run_d_ff;

////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_ACK = 3'h2;
localparam ST_RX = 3'h3;
localparam ST_TX = 3'h4;
localparam ST_MACK = 3'h5;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [3:0] bit_cnt_ff;
reg [7:0] shift_ff;
reg [3:0] ptr_ff;
reg read_ff;
reg first_byte_ff;
reg sda_drive_ff;
reg ack_next_ff;
reg [7:0] ctrl_ff;
reg [7:0] charge_ff;
reg osf_ff;
reg ctrl_wr_ff;
reg [3:0] ptr_inc;
localparam [7:0] FLAG_RST_VAL = `RTCS_FLAG_RESET;

// pointer advance with wrap
always @* begin
  if (ptr_ff == `RTCS_ADDR_LAST_CLOCK) begin
    ptr_inc = `RTCS_PTR_RESET;
  end else if (ptr_ff >= `RTCS_ADDR_LAST) begin
    ptr_inc = `RTCS_PTR_RESET;
  end else begin
    ptr_inc = ptr_ff + 4'h1;
  end
end

reg [7:0] rd_mux;
always @* begin
  case (ptr_ff)
    `RTCS_ADDR_CTRL: rd_mux = ctrl_ff;
    `RTCS_ADDR_CHARGE: rd_mux = charge_ff;
    `RTCS_ADDR_FLAG: rd_mux = {osf_ff, 7'h00};
    default: rd_mux = time_rd_data;
  endcase
end
assign time_rd_addr = ptr_ff;

////////////////////////////////////////////////////////////////////////
// byte engine, stepped on bus clock edges
wire byte_done = scl_rise && bit_cnt_ff == `RTCS_LAST_BIT;
wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
wire wr_data = (state_ff == ST_RX) && byte_done && !first_byte_ff;

always @(posedge ref_clk) begin
  if (!rst_b) begin
    state_ff <= ST_IDLE;
    bit_cnt_ff <= 4'h0;
    shift_ff <= 8'h00;
    ptr_ff <= `RTCS_PTR_RESET;
    read_ff <= 1'b0;
    first_byte_ff <= 1'b0;
    sda_drive_ff <= 1'b0;
    ack_next_ff <= 1'b0;
    time_wr_strobe <= 1'b0;
    time_wr_addr <= 4'h0;
    time_wr_data <= 8'h00;
  end else begin
    time_wr_strobe <= 1'b0;
    if (start_cond) begin
      state_ff <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_drive_ff <= 1'b0;
    end else if (stop_cond) begin
      state_ff <= ST_IDLE;
      sda_drive_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_ff <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          if (byte_done && state_ff == ST_ADDR) begin
            if (rx_byte[7:1] == `RTCS_SLAVE_ADDR) begin
              read_ff <= rx_byte[0];
              first_byte_ff <= !rx_byte[0];
              ack_next_ff <= 1'b1;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
          if (byte_done && state_ff == ST_RX) begin
            ack_next_ff <= 1'b1;
            if (first_byte_ff) begin
              ptr_ff <= rx_byte[3:0];
              first_byte_ff <= 1'b0;
            end else begin
              time_wr_strobe <= (ptr_ff < `RTCS_ADDR_CTRL);
              time_wr_addr <= ptr_ff;
              time_wr_data <= rx_byte;
              ptr_ff <= ptr_inc;
            end
          end
          if (scl_fall && ack_next_ff) begin
            ack_next_ff <= 1'b0;
            sda_drive_ff <= 1'b1;
            state_ff <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (read_ff) begin
              // read begins at pointer left by last access
              shift_ff <= rd_mux;
              sda_drive_ff <= !rd_mux[7];
              state_ff <= ST_TX;
            end else begin
              sda_drive_ff <= 1'b0;
              state_ff <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          if (scl_fall) begin
            if (bit_cnt_ff == `RTCS_ACK_BIT) begin
              sda_drive_ff <= 1'b0;
              ptr_ff <= ptr_inc;
              state_ff <= ST_MACK;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sda_drive_ff <= !shift_ff[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            // master nack ends the read with the line released
            if (sda_s) begin
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_ACK;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
end

assign sda_out = 1'b0;
assign sda_oe = sda_drive_ff;

////////////////////////////////////////////////////////////////////////
// special-purpose registers
wire wr_ctrl = wr_data && ptr_ff == `RTCS_ADDR_CTRL;
wire wr_charge = wr_data && ptr_ff == `RTCS_ADDR_CHARGE;
wire wr_flag = wr_data && ptr_ff == `RTCS_ADDR_FLAG;
wire wr_sec = wr_data && ptr_ff == `RTCS_ADDR_SEC;

always @(posedge ref_clk) begin
  if (!rst_b) begin
    ctrl_ff <= `RTCS_CTRL_RESET;
    charge_ff <= `RTCS_CHARGE_RESET;
    osf_ff <= FLAG_RST_VAL[`RTCS_FLAG_OSF_BIT];
    osc_disable_bit <= 1'b0;
    ctrl_wr_ff <= 1'b0;
  end else begin
    ctrl_wr_ff <= wr_ctrl;
    if (wr_ctrl) begin
      ctrl_ff <= rx_byte;
    end
    if (wr_charge) begin
      charge_ff <= rx_byte;
    end
    if (wr_sec) begin
      osc_disable_bit <= rx_byte[`RTCS_SEC_OSC_DIS_BIT];
    end
    // a stop event wins over a same-cycle clear
    if (osc_stop_edge || (wr_sec && rx_byte[`RTCS_SEC_OSC_DIS_BIT])) begin
      osf_ff <= 1'b1;
    end else if (wr_flag && !rx_byte[`RTCS_FLAG_OSF_BIT]) begin
      osf_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// charger decode
reg key_ok;
reg diode_ok;
reg res_ok;
always @* begin
  key_ok = charge_ff[7:4] == `RTCS_CHARGE_KEY;
  res_ok = charge_ff[1:0] != `RTCS_RES_OFF;
  case (charge_ff[3:2])
    `RTCS_DIODE_NONE: diode_ok = 1'b1;
    `RTCS_DIODE_ONE: diode_ok = 1'b1;
    default: diode_ok = 1'b0;
  endcase
end

always @(posedge ref_clk) begin
  if (!rst_b) begin
    charge_enable <= 1'b0;
    diode_select_field <= 1'b0;
    resistor_select_field <= 2'h0;
  end else begin
    charge_enable <= key_ok && diode_ok && res_ok;
    diode_select_field <= charge_ff[3:2] == `RTCS_DIODE_ONE;
    resistor_select_field <= charge_ff[1:0];
  end
end

////////////////////////////////////////////////////////////////////////
wire ft_square;
wire div_sec_pulse;

rtcs_trim_divider u_div (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .osc_tick(osc_tick && !osc_disable_bit),
  .div_clear(ctrl_wr_ff || wr_sec),
  .trim_magnitude(ctrl_ff[4:0]),
  .trim_sign(ctrl_ff[`RTCS_CTRL_SIGN_BIT]),
  .ft_square_ff(ft_square),
  .sec_pulse_ff(div_sec_pulse)
);

always @(posedge ref_clk) begin
  if (!rst_b) begin
    test_output_pin <= 1'b1;
    sec_pulse <= 1'b0;
  end else begin
    if (ctrl_ff[`RTCS_CTRL_FT_BIT]) begin
      test_output_pin <= ft_square;
    end else begin
      test_output_pin <= ctrl_ff[`RTCS_CTRL_OUT_BIT];
    end
    sec_pulse <= div_sec_pulse;
  end
end

endmodule

// >>> verification/rtcs_bus_master.sv
// two-wire bus master model driving clock and data
`timescale 1ns/1ps
module rtcs_bus_master (
  input wire ref_clk,
  input wire sda_wire,
  output reg scl,
  output reg sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task tk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // 80 ns per bit: low 60 ns, high 20 ns, data moved mid-low
  task bitx(input logic b, output logic v);
    sda_drv = b;
    tk(3);
    scl = 1'b1;
    tk(1);
    v = sda_wire;
    tk(1);
    scl = 1'b0;
    tk(3);
  endtask
  task start_c;
    sda_drv = 1'b1;
    tk(3);
    scl = 1'b1;
    tk(4);
    sda_drv = 1'b0;
    tk(4);
    scl = 1'b0;
    tk(3);
  endtask
  task stop_c;
    sda_drv = 1'b0;
    tk(3);
    scl = 1'b1;
    tk(4);
    sda_drv = 1'b1;
    tk(8);
  endtask
  task wbyte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bitx(b[i], v);
    bitx(1'b1, v);
    ack = ~v;
  endtask
  task rbyte(input logic last, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(last, v);
  endtask
endmodule

// >>> verification/rtcs_serial_slave_asserts.sv
// port assertions for the two-wire calendar clock slave
`timescale 1ns/1ps
module rtcs_asserts (
  input wire ref_clk,
  input wire rst_b,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire charge_enable,
  input wire [1:0] resistor_select_field,
  input wire osc_disable_bit,
  input wire time_wr_strobe,
  input wire [3:0] time_wr_addr,
  input wire [3:0] time_rd_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  idle_release_a: assert property (scl_in [*6] |-> !sda_oe)
    else $error("data held low while clock idles high");
  charge_res_a: assert property (charge_enable |-> resistor_select_field != 2'h0)
    else $error("charger on with resistor off");
  ptr_range_a: assert property (time_rd_addr <= 4'h9)
    else $error("pointer beyond last register");
  strobe_addr_a: assert property (time_wr_strobe |-> time_wr_addr <= 4'h6)
    else $error("time write outside time registers");
  strobe_pulse_a: assert property (time_wr_strobe |=> !time_wr_strobe)
    else $error("time write strobe longer than one cycle");
  disable_src_a: assert property ($changed(osc_disable_bit) |->
    time_wr_strobe || $past(time_wr_strobe) || $past(time_wr_strobe, 2))
    else $error("oscillator disable moved without a write");
endmodule
bind rtcs_serial_slave rtcs_asserts u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .charge_enable(charge_enable),
  .resistor_select_field(resistor_select_field), .osc_disable_bit(osc_disable_bit),
  .time_wr_strobe(time_wr_strobe), .time_wr_addr(time_wr_addr), .time_rd_addr(time_rd_addr));

// >>> verification/rtcs_serial_slave_tb_top.sv
// self-checking bench for the calendar clock serial slave
`timescale 1ns/1ps
module rtcs_serial_slave_tb_top;
  logic ref_clk, rst_b, osc_raw, run_ok;
  wire scl, mdrv, sda_oe, sda_out, sda, tpin, cen, dsel, odis, wstb;
  wire [1:0] rsel;
  wire [7:0] wdat;
  wire [3:0] waddr, raddr;
  logic [7:0] tmem [0:7] = '{default: 8'h00};
  int error_cnt, checks_done;
  assign sda = mdrv & ~sda_oe;
  rtcs_serial_slave dut (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .osc_clk_in(osc_raw & run_ok & ~odis), .osc_running_in(run_ok & ~odis),
    .test_output_pin(tpin), .charge_enable(cen), .diode_select_field(dsel), .resistor_select_field(rsel),
    .osc_disable_bit(odis), .sec_pulse(), .time_wr_data(wdat), .time_wr_addr(waddr),
    .time_wr_strobe(wstb), .time_rd_data(tmem[raddr[2:0]]), .time_rd_addr(raddr));
  rtcs_bus_master m (.ref_clk(ref_clk), .sda_wire(sda), .scl(scl), .sda_drv(mdrv));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    osc_raw = 1'b0;
    forever #40 osc_raw = ~osc_raw;
  end
  always @(posedge ref_clk) if (wstb) tmem[waddr[2:0]] <= wdat;
  ////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wb(input logic [7:0] b);
    logic a;
    m.wbyte(b, a);
    chk("ack", 8'h01, {7'h0, a});
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d);
    m.start_c;
    wb(8'hD0);
    wb(p);
    wb(d);
    m.stop_c;
  endtask
  task rdc(output logic [7:0] d);
    wb(8'hD1);
    m.rbyte(1'b1, d);
    chk("release", 8'h00, {7'h0, sda_oe});
    m.stop_c;
  endtask
  task rd(input logic [7:0] p, output logic [7:0] d);
    m.start_c;
    wb(8'hD0);
    wb(p);
    m.start_c;
    rdc(d);
  endtask
  ////////////////////////////////////////////////////////////////
  task s_reset;
    logic [7:0] d;
    chk("pin", 8'h01, {7'h0, tpin});
    chk("cen", 8'h00, {7'h0, cen});
    rd(8'h09, d);
    chk("flag", 8'h80, d);
    chk("ptr", 8'h00, {4'h0, raddr});
  endtask
  task chg(input logic [7:0] v, input logic en, input logic dd);
    logic [7:0] d;
    wr(8'h08, v);
    chk("cen", {7'h0, en}, {7'h0, cen});
    if (en) chk("dsel", {7'h0, dd}, {7'h0, dsel});
    chk("rsel", {6'h0, v[1:0]}, {6'h0, rsel});
    rd(8'h08, d);
    chk("chg", v, d);
  endtask
  task s_flag;
    logic [7:0] d;
    wr(8'h09, 8'hFF);
    rd(8'h09, d);
    chk("flag", 8'h80, d);
    wr(8'h09, 8'h7F);
    rd(8'h09, d);
    chk("flag", 8'h00, d);
    wr(8'h09, 8'hFF);
    rd(8'h09, d);
    chk("flag", 8'h00, d);
    run_ok = 1'b0;
    m.tk(8);
    run_ok = 1'b1;
    rd(8'h09, d);
    chk("flag", 8'h80, d);
    wr(8'h09, 8'h00);
    wr(8'h00, 8'h80);
    chk("odis", 8'h01, {7'h0, odis});
    rd(8'h09, d);
    chk("flag", 8'h80, d);
    wr(8'h00, 8'h00);
    chk("odis", 8'h00, {7'h0, odis});
  endtask
  task s_ptr;
    logic [7:0] d;
    m.start_c;
    wb(8'hD0);
    wb(8'h06);
    wb(8'h59);
    wb(8'h80);
    wb(8'h12);
    m.stop_c;
    chk("ptr", 8'h01, {4'h0, raddr});
    chk("sec", 8'h12, tmem[0]);
    wr(8'h08, 8'h00);
    m.start_c;
    rdc(d);
    chk("flag", 8'h80, d);
    m.start_c;
    rdc(d);
    chk("sec", 8'h12, d);
  endtask
  task s_naddr;
    logic a;
    m.start_c;
    m.wbyte(8'hD2, a);
    chk("nack", 8'h00, {7'h0, a});
    m.wbyte(8'h09, a);
    chk("ignored", 8'h00, {7'h0, a});
    m.stop_c;
  endtask
  task wchg(output int n);
    logic p;
    p = tpin;
    n = 0;
    while (tpin === p) begin
      m.tk(1);
      n++;
      if (n > 999) begin
        error_cnt++;
        close_out;
      end
    end
  endtask
  // osc period 8 cycles: half wave of osc/64 is 256 cycles
  task s_ft(input logic [7:0] c);
    int n;
    wr(8'h07, c);
    wchg(n);
    wchg(n);
    chk("half", 8'h01, {7'h0, n >= 254 && n <= 258});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    run_ok = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    m.tk(6);
    s_reset;
    chg(8'hA5, 1'b1, 1'b0);
    chg(8'hAB, 1'b1, 1'b1);
    chg(8'hA6, 1'b1, 1'b0);
    chg(8'hA9, 1'b1, 1'b1);
    chg(8'hAD, 1'b0, 1'b0);
    chg(8'hA4, 1'b0, 1'b0);
    chg(8'h5A, 1'b0, 1'b0);
    s_flag;
    s_ptr;
    s_naddr;
    s_ft(8'h40);
    s_ft(8'h7F);
    s_ft(8'h5F);
    close_out;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    close_out;
  end
endmodule
